// File: sys_addr_router.sv
/*
 * system address decoder and router. one request port in; it decodes the
 * address, answers sram and bit-band itself, forwards external ram to the
 * external memory sequencer, answers decode errors with an error, and routes
 * the rest to a downstream port tagged with target bus and peripheral index.
 * assumes a single bus clock, one outstanding request, and downstream
 * targets that answer with i_dn_ready within bounded time.
 */
module sys_addr_router
    import addr_map_pkg::*;
//
// What this block does
// - lowest half gigabyte is code, vectors at zero
// - flash 256 KB at zero, SRAM half at top
// - second SRAM half at SRAM region base
// - bit-band area plus 32 MB alias region
// - SRAM bits read or written atomically
// - alias write uses bit 0 only
// - alias read returns zero or one
// - peripheral region split into fixed sub-ranges
// - top half gigabyte is internal peripherals
// - first megabyte there goes to private bus
// - private bus only for system, debug registers
// - code buses carry code region accesses only
// - system bus covers SRAM through external, high
// - system bus also takes SRAM region fetches
// - unaligned word, halfword accesses clipped to word
// - external RAM forwarded, 24 address bits
// - external access reads, writes, four cycles
// - one external memory type, sync or async
// - external data path 8 or 16 bits
// - external fetch only when 16 bits wide
// - no code protection on external memory
(
    input wire logic I_CLK,
    input wire logic I_RESETN,
    input wire logic I_REQ,
    input wire logic I_WRITE,
    input wire logic I_FETCH,
    input wire logic [1:0] I_SIZE,
    input wire logic [31:0] I_ADDR,
    input wire logic [31:0] I_WDATA,
    input wire logic I_XMEM_SYNC,
    input wire logic I_XMEM_WIDE,
    input wire logic I_DN_READY,
    input wire logic [31:0] I_DN_RDATA,
    input wire logic I_DN_ERR,
    input wire logic [15:0] I_XMEM_RDATA,
    output logic O_READY,
    output logic O_ERR,
    output logic [31:0] O_RDATA,
    output logic O_DN_REQ,
    output logic O_DN_WRITE,
    output logic [2:0] O_DN_TARGET,
    output logic [1:0] O_DN_BUS,
    output logic [4:0] O_DN_PER_IDX,
    output logic [31:0] O_DN_ADDR,
    output logic [31:0] O_DN_WDATA,
    output logic [3:0] O_DN_BE,
    output logic [XMEM_AW-1:0] O_XMEM_ADDR,
    output logic [15:0] O_XMEM_WDATA,
    output logic O_XMEM_OE,
    output logic O_XMEM_WE,
    output logic O_XMEM_CE,
    output logic O_XMEM_CLK_EN
);
    typedef enum logic [2:0]
    {
        ST_IDLE = 3'b000,
        ST_SRAM = 3'b001,
        ST_RMW = 3'b010,
        ST_DOWN = 3'b011,
        ST_XMEM = 3'b100,
        ST_XWAIT = 3'b101,
        ST_DONE = 3'b110
    } state_t;

    state_t state_reg, state_next;
    logic [31:0] sram [0:(1<<SRAM_AW)-1]; // both 32 KB halves, contiguous
    target_t target; // decoded target of the incoming address
    bus_t bus; // request bus of the incoming address
    logic is_alias, dec_err;
    logic [4:0] per_idx;
    logic [31:0] addr_reg, wdata_reg, rdword_reg;
    logic write_reg, alias_reg, xhalf_reg, xsync_reg, xwide_reg;
    logic [3:0] be_reg;
    logic [SRAM_AW-1:0] widx; // sram word index, plain or alias
    logic [4:0] bitno; // alias bit within target word
    logic [3:0] be_calc;
    logic x_start, x_done;
    logic [15:0] x_rdata;
    logic [31:0] merged;
    logic [15:0] xrd_meta_reg, xrd_sync_reg; // pin data, two stages

    region_decode u_dec (
        .i_addr(I_ADDR),
        .i_fetch(I_FETCH),
        .i_xmem_wide(I_XMEM_WIDE),
        .o_target(target),
        .o_bus(bus),
        .o_alias(is_alias),
        .o_per_idx(per_idx),
        .o_err(dec_err)
    );

    // alias word -> sram word and bit; the sram window sits at alias/32
    assign bitno = addr_reg[6:2];
    assign widx = alias_reg ? {~addr_reg[SRAM_AW+6], addr_reg[SRAM_AW+5:7]}
                : (addr_reg[31] ? 14'h0 : {~addr_reg[15], addr_reg[14:2]}) ;
    // byte enables from size and low address bits; crossing words clip
    assign be_calc = (I_SIZE == 2'b00) ? (4'h1 << I_ADDR[1:0])
                   : (I_SIZE == 2'b01) ? (I_ADDR[1:0] == 2'b11 ? 4'h8 : 4'(4'h3 << I_ADDR[1:0]))
                   : 4'(4'hf << I_ADDR[1:0]);
    // bit-band set or clear of one bit, rest untouched
    assign merged = wdata_reg[0] ? (rdword_reg | (32'h1 << bitno))
                                 : (rdword_reg & ~(32'h1 << bitno));
    assign x_start = (state_reg == ST_XMEM);

    // read pins come from off chip: two flops before use
    always_ff @(posedge I_CLK)
    begin
        xrd_meta_reg <= I_XMEM_RDATA;
        xrd_sync_reg <= xrd_meta_reg;
    end

    xmem_seq u_xmem (
        .i_clk(I_CLK),
        .i_resetn(I_RESETN),
        .i_start(x_start),
        .i_write(write_reg),
        .i_wide(xwide_reg),
        .i_addr(addr_reg[XMEM_AW-1:0]),
        .i_wdata(xhalf_reg ? wdata_reg[31:16] : wdata_reg[15:0]),
        .i_pin_rdata(xrd_sync_reg),
        .o_busy(),
        .o_done(x_done),
        .o_rdata(x_rdata),
        .o_pin_addr(O_XMEM_ADDR),
        .o_pin_wdata(O_XMEM_WDATA),
        .o_pin_oe(O_XMEM_OE),
        .o_pin_we(O_XMEM_WE),
        .o_pin_ce(O_XMEM_CE)
    );

    // next state; one request in flight at a time
    always_comb
    begin
        state_next = state_reg;
        case (state_reg)
            ST_IDLE:
            begin
                if (I_REQ && dec_err)
                begin
                    state_next = ST_DONE;
                end
                else if (I_REQ && target == TGT_SRAM)
                begin
                    state_next = ST_SRAM;
                end
                else if (I_REQ && target == TGT_XMEM)
                begin
                    state_next = ST_XMEM;
                end
                else if (I_REQ)
                begin
                    state_next = ST_DOWN;
                end
            end

            ST_SRAM:
            begin
                state_next = (alias_reg && write_reg) ? ST_RMW : ST_DONE;
            end

            ST_RMW: state_next = ST_DONE;

            ST_DOWN:
            begin
                if (I_DN_READY)
                begin
                    state_next = ST_DONE;
                end
            end

            ST_XMEM: state_next = ST_XWAIT;

            ST_XWAIT:
            begin
                if (x_done)
                begin
                    state_next = ST_DONE;
                end
            end

            ST_DONE: state_next = ST_IDLE;

            default: state_next = ST_IDLE;
        endcase
    end

    // request capture, sram port and answer registers
    always_ff @(posedge I_CLK)
    begin
        if (!I_RESETN)
        begin
            state_reg <= ST_IDLE;
            addr_reg <= 32'h0000_0000;
            wdata_reg <= 32'h0000_0000;
            rdword_reg <= 32'h0000_0000;
            write_reg <= 1'b0;
            alias_reg <= 1'b0;
            xhalf_reg <= 1'b0;
            xsync_reg <= 1'b0;
            xwide_reg <= 1'b0;
            be_reg <= 4'h0;
            O_READY <= 1'b0;
            O_ERR <= 1'b0;
            O_RDATA <= 32'h0000_0000;
            O_DN_REQ <= 1'b0;
            O_DN_WRITE <= 1'b0;
            O_DN_TARGET <= 3'h0;
            O_DN_BUS <= 2'h0;
            O_DN_PER_IDX <= 5'h00;
            O_DN_ADDR <= 32'h0000_0000;
            O_DN_WDATA <= 32'h0000_0000;
            O_DN_BE <= 4'h0;
            O_XMEM_CLK_EN <= 1'b0;
        end
        else
        begin
            state_reg <= state_next;
            O_READY <= 1'b0;
            O_ERR <= 1'b0;
            // external type taken with each request, enable follows it
            O_XMEM_CLK_EN <= xsync_reg;

            if (state_reg == ST_IDLE && I_REQ)
            begin
                addr_reg <= I_ADDR;
                wdata_reg <= I_WDATA;
                write_reg <= I_WRITE;
                alias_reg <= is_alias;
                be_reg <= be_calc;
                xhalf_reg <= I_ADDR[1];
                xsync_reg <= I_XMEM_SYNC;
                xwide_reg <= I_XMEM_WIDE;
                O_ERR <= 1'b0;
                if (!dec_err && target != TGT_SRAM && target != TGT_XMEM)
                begin
                    O_DN_REQ <= 1'b1;
                    O_DN_WRITE <= I_WRITE;
                    O_DN_TARGET <= target;
                    O_DN_BUS <= bus;
                    O_DN_PER_IDX <= per_idx;
                    O_DN_ADDR <= I_ADDR;
                    O_DN_WDATA <= I_WDATA;
                    O_DN_BE <= be_calc;
                end
            end

            if (state_reg == ST_SRAM)
            begin
                rdword_reg <= sram[widx];
                if (write_reg && !alias_reg)
                begin
                    for (int b = 0; b < 4; b++)
                    begin
                        if (be_reg[b])
                        begin
                            sram[widx][8*b +: 8] <= wdata_reg[8*b +: 8];
                        end
                    end
                end
                O_RDATA <= alias_reg ? {31'h0, sram[widx][bitno]} : sram[widx];
            end

            if (state_reg == ST_RMW)
            begin
                sram[widx] <= merged;
            end

            if (state_reg == ST_DOWN && I_DN_READY)
            begin
                O_DN_REQ <= 1'b0;
                O_RDATA <= I_DN_RDATA;
                O_ERR <= I_DN_ERR;
            end

            if (state_reg == ST_XWAIT && x_done)
            begin
                O_RDATA <= xhalf_reg ? {x_rdata, 16'h0000} : {16'h0000, x_rdata};
            end

            if (state_next == ST_DONE && state_reg != ST_DONE)
            begin
                O_READY <= 1'b1;
                O_ERR <= (state_reg == ST_IDLE) ? 1'b1
                       : (state_reg == ST_DOWN) ? I_DN_ERR : 1'b0;
            end
        end
    end
endmodule // sys_addr_router

// File: addr_map_pkg.sv
/*
 * address map constants for the system address decoder: region bases,
 * sub-range bounds, bit-band layout, external memory timing.
 * assumes a single bus clock and synchronous active-low reset.
 */
package addr_map_pkg;
    // top-level regions
    localparam logic [31:0] CODE_BASE = 32'h0000_0000;
    localparam logic [31:0] CODE_LAST = 32'h1fff_ffff;
    localparam logic [31:0] SRAM_RGN_BASE = 32'h2000_0000;
    localparam logic [31:0] SRAM_RGN_LAST = 32'h3fff_ffff;
    localparam logic [31:0] PERIPH_BASE = 32'h4000_0000;
    localparam logic [31:0] PERIPH_LAST = 32'h5fff_ffff;
    localparam logic [31:0] XRAM_BASE = 32'h6000_0000;
    localparam logic [31:0] XRAM_LAST = 32'h9fff_ffff;
    localparam logic [31:0] XPERIPH_BASE = 32'ha000_0000;
    localparam logic [31:0] XPERIPH_LAST = 32'hdfff_ffff;
    localparam logic [31:0] INTPERIPH_BASE = 32'he000_0000;
    localparam logic [31:0] PRIV_LAST = 32'he00f_ffff;
    // memories
    localparam logic [31:0] FLASH_LAST = 32'h0003_ffff;
    localparam logic [31:0] SRAM_LO_BASE = 32'h1fff_8000;
    localparam logic [31:0] SRAM_HI_LAST = 32'h2000_7fff;
    localparam logic [31:0] ALIAS_BASE = 32'h2200_0000;
    localparam logic [31:0] ALIAS_LAST = 32'h23ff_ffff;
    localparam logic [31:0] BITBAND_BASE = 32'h2000_0000;
    // sram words, 64 KB total
    localparam int SRAM_AW = 14;
    // external memory interface
    localparam int XMEM_AW = 24;
    localparam int XMEM_ACCESS_CYCLES = 4;
    // peripheral sub-ranges, one entry each
    localparam int NPER = 18;
    typedef logic [31:0] addr_t;
    localparam addr_t PER_LO [NPER] = '{
        32'h4000_4000, 32'h4000_4300, 32'h4000_4500, 32'h4000_4700, 32'h4000_4800, 32'h4000_4900,
        32'h4000_4e00, 32'h4000_4f00, 32'h4000_5000, 32'h4000_5400, 32'h4000_5800, 32'h4000_6000,
        32'h4000_6400, 32'h4000_7000, 32'h4000_8000, 32'h4000_a000, 32'h4000_c000, 32'h4001_0000};
    localparam addr_t PER_HI [NPER] = '{
        32'h4000_42ff, 32'h4000_43ff, 32'h4000_45ff, 32'h4000_47ff, 32'h4000_48ff, 32'h4000_49ff,
        32'h4000_4eff, 32'h4000_4fff, 32'h4000_51ff, 32'h4000_54ff, 32'h4000_5fff, 32'h4000_60ff,
        32'h4000_6fff, 32'h4000_7fff, 32'h4000_87ff, 32'h4000_a400, 32'h4000_c800, 32'h4001_ffff};
    // routing targets
    typedef enum logic [2:0]
    {
        TGT_NONE = 3'b000,
        TGT_FLASH = 3'b001,
        TGT_SRAM = 3'b010,
        TGT_PERIPH = 3'b011,
        TGT_XMEM = 3'b100,
        TGT_XPERIPH = 3'b101,
        TGT_PRIV = 3'b110,
        TGT_SYSHI = 3'b111
    } target_t;
    // request bus that carries the access
    typedef enum logic [1:0]
    {
        BUS_CODE_I = 2'b00,
        BUS_CODE_D = 2'b01,
        BUS_SYS = 2'b10,
        BUS_PRIV = 2'b11
    } bus_t;
endpackage

// File: region_decode.sv
/*
 * combinational address decoder: region, target and peripheral index.
 * assumes the address is stable while i_addr is being decoded.
 */
module region_decode
    import addr_map_pkg::*;
(
    input wire logic [31:0] i_addr,
    input wire logic i_fetch,
    input wire logic i_xmem_wide,
    output target_t o_target,
    output bus_t o_bus,
    output logic o_alias,
    output logic [4:0] o_per_idx,
    output logic o_err
);
    logic [NPER-1:0] per_hit; // one bit per peripheral sub-range
    logic in_code, in_sram_rgn, in_per, in_xram, in_xper, in_int, in_priv;
    logic hit_flash, hit_sram, hit_alias, per_any;

    // region compares
    assign in_code = (i_addr <= CODE_LAST);
    assign in_sram_rgn = (i_addr >= SRAM_RGN_BASE) && (i_addr <= SRAM_RGN_LAST);
    assign in_per = (i_addr >= PERIPH_BASE) && (i_addr <= PERIPH_LAST);
    assign in_xram = (i_addr >= XRAM_BASE) && (i_addr <= XRAM_LAST);
    assign in_xper = (i_addr >= XPERIPH_BASE) && (i_addr <= XPERIPH_LAST);
    assign in_int = (i_addr >= INTPERIPH_BASE);
    assign in_priv = in_int && (i_addr <= PRIV_LAST);
    assign hit_flash = (i_addr <= FLASH_LAST);
    assign hit_sram = (i_addr >= SRAM_LO_BASE) && (i_addr <= SRAM_HI_LAST);
    assign hit_alias = (i_addr >= ALIAS_BASE) && (i_addr <= ALIAS_LAST);

    // one comparator pair per peripheral sub-range
    genvar g;
    generate
        for (g = 0; g < NPER; g++)
        begin : g_per
            assign per_hit[g] = in_per && (i_addr >= PER_LO[g]) && (i_addr <= PER_HI[g]);
        end
    endgenerate
    assign per_any = |per_hit;

    // priority encode the hit, sub-ranges never overlap
    always_comb
    begin
        o_per_idx = 5'h00;
        for (int k = 0; k < NPER; k++)
        begin
            if (per_hit[k])
            begin
                o_per_idx = 5'(k);
            end
        end
    end

    // target selection; unmapped holes give none
    always_comb
    begin
        o_target = TGT_NONE;
        o_alias = 1'b0;
        if (in_code && hit_flash)
        begin
            o_target = TGT_FLASH;
        end
        else if (hit_sram)
        begin
            o_target = TGT_SRAM;
        end
        else if (hit_alias)
        begin
            o_target = TGT_SRAM;
            o_alias = 1'b1;
        end
        else if (per_any)
        begin
            o_target = TGT_PERIPH;
        end
        else if (in_xram && i_addr[31:XMEM_AW] == XRAM_BASE[31:XMEM_AW])
        begin
            o_target = TGT_XMEM;
        end
        else if (in_xper)
        begin
            o_target = TGT_XPERIPH;
        end
        else if (in_priv)
        begin
            o_target = TGT_PRIV;
        end
        else if (in_int)
        begin
            o_target = TGT_SYSHI;
        end
    end

    // bus choice: code buses only inside code region
    assign o_bus = in_code ? (i_fetch ? BUS_CODE_I : BUS_CODE_D)
                 : (in_priv ? BUS_PRIV : BUS_SYS);

    // fetches: never from peripherals or private space; xmem only when wide
    assign o_err = (o_target == TGT_NONE)
                 || (i_fetch && !(in_code || in_sram_rgn || in_xram))
                 || (i_fetch && o_alias)
                 || (i_fetch && o_target == TGT_XMEM && !i_xmem_wide);
endmodule // region_decode

// File: xmem_seq.sv
/*
 * external memory access sequencer: holds one access for a fixed number
 * of bus cycles and drives address, data and strobes to the pins.
 * assumes the read data pins settle before the last cycle.
 */
module xmem_seq
    import addr_map_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_resetn,
    input wire logic i_start,
    input wire logic i_write,
    input wire logic i_wide,
    input wire logic [XMEM_AW-1:0] i_addr,
    input wire logic [15:0] i_wdata,
    input wire logic [15:0] i_pin_rdata,
    output logic o_busy,
    output logic o_done,
    output logic [15:0] o_rdata,
    output logic [XMEM_AW-1:0] o_pin_addr,
    output logic [15:0] o_pin_wdata,
    output logic o_pin_oe,
    output logic o_pin_we,
    output logic o_pin_ce
);
    logic [2:0] cnt_reg; // cycles left in access
    logic wr_reg;
    wire last = (cnt_reg == 3'h1);

    // every access takes the fixed count, reads and writes alike
    always_ff @(posedge i_clk)
    begin
        if (!i_resetn)
        begin
            cnt_reg <= 3'h0;
            wr_reg <= 1'b0;
            o_pin_addr <= '0;
            o_pin_wdata <= 16'h0000;
            o_rdata <= 16'h0000;
            o_done <= 1'b0;
        end
        else
        begin
            o_done <= 1'b0;
            if (cnt_reg == 3'h0 && i_start)
            begin
                cnt_reg <= 3'(XMEM_ACCESS_CYCLES);
                wr_reg <= i_write;
                o_pin_addr <= i_addr;
                o_pin_wdata <= i_wide ? i_wdata : {8'h00, i_wdata[7:0]};
            end
            else if (cnt_reg != 3'h0)
            begin
                cnt_reg <= cnt_reg - 3'h1;
                if (last)
                begin
                    o_done <= 1'b1;
                    o_rdata <= i_wide ? i_pin_rdata : {8'h00, i_pin_rdata[7:0]};
                end
            end
        end
    end
    assign o_busy = (cnt_reg != 3'h0);
    assign o_pin_ce = o_busy;
    assign o_pin_we = o_busy && wr_reg;
    assign o_pin_oe = o_busy && !wr_reg;
endmodule // xmem_seq

// File: sys_addr_router_props.sv
/*
 * checker on the router's top-level ports.
 * assumes a bind from the bench, one clock.
 */
module sys_addr_router_props
    import addr_map_pkg::*;
(
    input wire logic I_CLK,
    input wire logic I_RESETN,
    input wire logic I_DN_READY,
    input wire logic O_READY,
    input wire logic O_ERR,
    input wire logic O_DN_REQ,
    input wire logic [2:0] O_DN_TARGET,
    input wire logic [1:0] O_DN_BUS,
    input wire logic [31:0] O_DN_ADDR,
    input wire logic O_XMEM_CE
);
    default clocking cb @(posedge I_CLK);
    endclocking
    default disable iff (!I_RESETN);
    // strobe high four cycles per access
    sequence ce_burst;
        O_XMEM_CE [*4] ##1 !O_XMEM_CE;
    endsequence
    // answer one cycle after the strobe falls
    sequence answer_next;
        ##1 O_READY;
    endsequence
    a_err_with_ready: assert property (O_ERR |-> O_READY)
        else $error("error flag without answer");
    a_dn_answer: assert property (O_DN_REQ && I_DN_READY |=> O_READY && !O_DN_REQ)
        else $error("downstream answer not passed on");
    a_dn_hold: assert property (O_DN_REQ && !I_DN_READY |=> O_DN_REQ && $stable(O_DN_ADDR))
        else $error("downstream request dropped early");
    a_ce_four: assert property ($rose(O_XMEM_CE) |-> ce_burst)
        else $error("external strobe not four cycles");
    a_xmem_answer: assert property ($fell(O_XMEM_CE) |-> answer_next)
        else $error("external access not answered");
    a_code_bus_only: assert property (O_DN_REQ |-> (O_DN_BUS[1] == 1'b0) == (O_DN_ADDR <= CODE_LAST))
        else $error("code bus carries wrong address");
    a_priv_range: assert property (O_DN_REQ |-> (O_DN_BUS == BUS_PRIV)
        == (O_DN_ADDR >= INTPERIPH_BASE && O_DN_ADDR <= PRIV_LAST))
        else $error("private bus range wrong");
    a_syshi_range: assert property (O_DN_REQ && O_DN_TARGET == TGT_SYSHI |-> O_DN_ADDR > PRIV_LAST)
        else $error("system high below private range");
    a_periph_target: assert property (O_DN_REQ && O_DN_ADDR >= PERIPH_BASE && O_DN_ADDR <= PERIPH_LAST
        |-> O_DN_TARGET == TGT_PERIPH)
        else $error("peripheral access misrouted");
    a_flash_target: assert property (O_DN_REQ && O_DN_ADDR <= FLASH_LAST |-> O_DN_TARGET == TGT_FLASH)
        else $error("flash access misrouted");
endmodule // sys_addr_router_props

// File: far_side_model.sv
/*
 * far side: downstream targets with an address-dependent wait,
 * and an external memory on the pins.
 * assumes the router's clock; errors on request.
 */
module far_side_model
    import addr_map_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_resetn,
    input wire logic i_fail,
    input wire logic i_req,
    input wire logic [31:0] i_addr,
    input wire logic i_oe,
    input wire logic i_ce,
    output logic o_ready,
    output logic [31:0] o_rdata,
    output logic o_err,
    output logic [15:0] o_xrdata
);
    localparam logic [15:0] XDATA = 16'hc3a5; // value the external device returns
    logic [3:0] wait_reg; // idle cycles spent on the current request
    logic [15:0] churn_reg; // changing filler so a released bus never looks valid
    // answer after addr[5:2] idle cycles
    always_ff @(posedge i_clk)
    begin
        churn_reg <= i_resetn ? churn_reg + 16'h3b1d : 16'h0001;
        if (!i_resetn || !i_req || o_ready)
        begin
            wait_reg <= 4'h0;
            o_ready <= 1'b0;
        end
        else if (wait_reg == i_addr[5:2])
            o_ready <= 1'b1;
        else
            wait_reg <= wait_reg + 4'h1;
    end
    assign o_rdata = o_ready ? ~i_addr : {churn_reg, ~churn_reg};
    assign o_err = o_ready & i_fail;
    // device drives its data only while selected and reading
    assign o_xrdata = (i_ce && i_oe) ? XDATA : churn_reg;
endmodule // far_side_model

// File: sys_addr_router_tb.sv
/*
 * self-checking bench for the address router.
 * assumes the far side model.
 */
module sys_addr_router_tb;
    import addr_map_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct {logic [31:0] d; logic e; logic [31:0] m;} exp_t;
    logic I_CLK, I_RESETN, I_REQ, I_WRITE, I_FETCH, I_XMEM_SYNC, I_XMEM_WIDE, I_DN_READY, I_DN_ERR, fail;
    logic [1:0] I_SIZE;
    logic [31:0] I_ADDR, I_WDATA, I_DN_RDATA, O_RDATA, O_DN_ADDR, O_DN_WDATA;
    logic [15:0] I_XMEM_RDATA, O_XMEM_WDATA;
    logic O_READY, O_ERR, O_DN_REQ, O_DN_WRITE, O_XMEM_OE, O_XMEM_WE, O_XMEM_CE, O_XMEM_CLK_EN;
    logic [2:0] O_DN_TARGET;
    logic [1:0] O_DN_BUS;
    logic [4:0] O_DN_PER_IDX;
    logic [3:0] O_DN_BE;
    logic [XMEM_AW-1:0] O_XMEM_ADDR;
    logic [31:0] seed = 32'h54, r, a;
    logic [4:0] b;
    exp_t q[$];
    int bad_count = 0;
    int checks_done = 0;
    sys_addr_router uut (.I_CLK, .I_RESETN, .I_REQ, .I_WRITE, .I_FETCH, .I_SIZE, .I_ADDR, .I_WDATA, .I_XMEM_SYNC,
        .I_XMEM_WIDE, .I_DN_READY, .I_DN_RDATA, .I_DN_ERR, .I_XMEM_RDATA, .O_READY, .O_ERR, .O_RDATA, .O_DN_REQ,
        .O_DN_WRITE, .O_DN_TARGET, .O_DN_BUS, .O_DN_PER_IDX, .O_DN_ADDR, .O_DN_WDATA, .O_DN_BE, .O_XMEM_ADDR,
        .O_XMEM_WDATA, .O_XMEM_OE, .O_XMEM_WE, .O_XMEM_CE, .O_XMEM_CLK_EN);
    far_side_model far (.i_clk(I_CLK), .i_resetn(I_RESETN), .i_fail(fail), .i_req(O_DN_REQ),
        .i_addr(O_DN_ADDR), .i_oe(O_XMEM_OE), .i_ce(O_XMEM_CE), .o_ready(I_DN_READY),
        .o_rdata(I_DN_RDATA), .o_err(I_DN_ERR), .o_xrdata(I_XMEM_RDATA));
    // free-running bus clock, 100 ns period
    initial
    begin
        I_CLK = 1'b0;
        forever #50 I_CLK = ~I_CLK;
    end
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", n, exp, seen);
        end
    endtask
    task automatic report_and_stop();
        if (bad_count == 0 && checks_done > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    // note the expectation, hold the request until answered
    task automatic go(input logic [31:0] ad, logic w, f, logic [1:0] sz, logic [31:0] wd, ed, logic ee, int ix);
        int n;
        logic [4:0] seen_ix;
        logic [31:0] m;
        n = 0;
        seen_ix = 5'h1f;
        m = (w || ee) ? 32'h0 : (ad >= XRAM_BASE && ad <= XRAM_LAST) ? (I_XMEM_WIDE ? 32'hffff : 32'hff) : '1;
        q.push_back('{ed & m, ee, m});
        @(negedge I_CLK);
        {I_REQ, I_WRITE, I_FETCH, I_SIZE, I_ADDR, I_WDATA} = {1'b1, w, f, sz, ad, wd};
        while (O_READY !== 1'b1 && n < 60)
        begin
            @(negedge I_CLK);
            if (O_DN_REQ === 1'b1)
                seen_ix = O_DN_PER_IDX;
            n++;
        end
        I_REQ = 1'b0;
        if (n >= 60)
            chk("answer", 32'(O_READY), 32'h1);
        if (ix >= 0)
            chk("sub-range index", 32'(seen_ix), 32'(ix));
    endtask
    task automatic rd(input logic [31:0] ad, logic f, logic [31:0] ed, logic ee, int ix);
        go(ad, 1'b0, f, 2'b10, 32'h0, ed, ee, ix);
    endtask
    // each answer against the oldest note
    always @(negedge I_CLK)
    begin
        if (O_READY === 1'b1)
        begin
            if (q.size() == 0)
                chk("unexpected answer", 32'(O_READY), 32'h0);
            else
            begin
                chk("bus error", 32'(O_ERR), 32'(q[0].e));
                chk("read data", O_RDATA & q[0].m, q[0].d);
                void'(q.pop_front());
            end
        end
    end
    // generous bound on the whole sequence
    initial
    begin
        repeat (20000) @(posedge I_CLK);
        bad_count++;
        report_and_stop();
    end
    initial
    begin
        {I_RESETN, I_REQ, I_WRITE, I_FETCH, I_SIZE, I_ADDR, I_WDATA, fail} = '0;
        {I_XMEM_SYNC, I_XMEM_WIDE} = 2'b11;
        repeat (10) @(negedge I_CLK);
        I_RESETN = 1'b1;
        go(32'h2000_0000, 1, 0, 2'b10, 32'h10, 0, 0, -1);
        go(32'h1fff_fffc, 1, 0, 2'b10, 32'ha5a5_0001, 0, 0, -1);
        rd(32'h1fff_fffc, 0, 32'ha5a5_0001, 0, -1);
        rd(32'h2000_0000, 0, 32'h10, 0, -1);
        go(32'h2200_000c, 1, 0, 2'b10, 32'h1, 0, 0, -1);
        go(32'h2200_0010, 1, 0, 2'b10, 32'hffff_fffe, 0, 0, -1);
        rd(32'h2000_0000, 0, 32'h8, 0, -1);
        rd(32'h2200_000c, 0, 32'h1, 0, -1);
        go(32'h2000_0100, 1, 0, 2'b10, 32'h0, 0, 0, -1);
        go(32'h2000_0102, 1, 0, 2'b01, 32'hbeef_beef, 0, 0, -1);
        rd(32'h2000_0100, 0, 32'hbeef_0000, 0, -1);
        // random words, one random bit read back through its alias, word by fetch
        repeat (4)
        begin
            r = xs();
            a = 32'h2000_0000 | {17'h0, r[14:2], 2'b00};
            b = r[31:27];
            go(a, 1, 0, 2'b10, r, 0, 0, -1);
            rd(32'h2200_0000 + (32'(a[14:0]) << 5) + (32'(b) << 2), 0, 32'(r[b]), 0, -1);
            rd(a, 1, r, 0, -1);
        end
        rd(32'h0003_fffc, 1, ~32'h0003_fffc, 0, -1);
        rd(32'h0000_0000, 0, ~32'h0, 0, -1);
        rd(32'h0004_0000, 0, 0, 1, -1);
        for (int i = 0; i < NPER; i++)
        begin
            rd(PER_LO[i], 0, ~PER_LO[i], 0, i);
            rd(PER_HI[i] & ~32'h3, 0, ~(PER_HI[i] & ~32'h3), 0, i);
        end
        rd(32'h4000_4400, 0, 0, 1, -1);
        rd(PER_LO[0], 1, 0, 1, -1);
        rd(32'he000_ed00, 0, ~32'he000_ed00, 0, -1);
        rd(32'he000_ed00, 1, 0, 1, -1);
        rd(32'he010_0000, 0, ~32'he010_0000, 0, -1);
        rd(32'ha000_0040, 0, ~32'ha000_0040, 0, -1);
        fail = 1'b1;
        rd(32'h4000_4000, 0, 0, 1, 0);
        fail = 1'b0;
        rd(32'h6000_0010, 0, 32'hc3a5, 0, -1);
        chk("clock enable", 32'(O_XMEM_CLK_EN), 32'h1);
        go(32'h6000_0012, 1, 0, 2'b01, 32'h1234_5678, 0, 0, -1);
        chk("ext data", 32'(O_XMEM_WDATA), 32'h1234);
        chk("ext addr", 32'(O_XMEM_ADDR), 32'h12);
        rd(32'h6000_0010, 1, 32'hc3a5, 0, -1);
        {I_XMEM_SYNC, I_XMEM_WIDE} = 2'b00;
        rd(32'h6000_0010, 0, 32'ha5, 0, -1);
        chk("clock enable", 32'(O_XMEM_CLK_EN), 32'h0);
        rd(32'h6000_0010, 1, 0, 1, -1);
        rd(32'h6100_0000, 0, 0, 1, -1);
        repeat (4) @(negedge I_CLK);
        chk("pending answers", 32'(q.size()), 32'h0);
        report_and_stop();
    end
endmodule // sys_addr_router_tb
bind sys_addr_router sys_addr_router_props props (.I_CLK, .I_RESETN, .I_DN_READY, .O_READY, .O_ERR, .O_DN_REQ,
    .O_DN_TARGET, .O_DN_BUS, .O_DN_ADDR, .O_XMEM_CE);
